// file: verilog/csm_pkg.sv
// Constants, register map and timing counts for the composite sync mode control block.
// Assumes a single 10 MHz clock and a plain strobed register port with 8-bit addresses.
// What this block does
// (RULE1) Dither bit written only with its enable.
// (RULE2) Dither enable dithers 24-bit RGB to 15-bit.
// (RULE3) Sync mode bits written only when bit 4 set.
// (RULE4) Composite select picks csync, else vsync.
// (RULE5) Bit 4 only qualifies, selects nothing.
// (RULE6) Interlace, disc-interactive, fifty-hertz shape csync.
package csm_pkg;

  // Register addresses on the plain port.
  localparam logic [7:0] CSM_ADDR_MODE_CTRL = 8'h0B;
  localparam logic [7:0] CSM_ADDR_STATUS = 8'h0C;

  // Field positions in the mode control word.
  localparam int CSM_BIT_FIFTY = 0;
  localparam int CSM_BIT_DISC = 1;
  localparam int CSM_BIT_CSEL = 2;
  localparam int CSM_BIT_ILACE = 3;
  localparam int CSM_BIT_MODE_WE = 4;
  localparam int CSM_BIT_DITHER = 5;
  localparam int CSM_BIT_DITHER_WE = 6;

  // Field positions in the status word.
  localparam int CSM_ST_FIELD = 4;
  localparam int CSM_ST_IN_VS = 5;
  localparam int CSM_ST_SYNC = 6;

  // Reset values: interlace on, all other modes off.
  localparam logic [3:0] CSM_RST_SYNC_MODE = 4'h8;
  localparam logic CSM_RST_DITHER = 1'b0;

  // Clock period in nanoseconds.
  localparam int CSM_CLK_NS = 100;

  // Line periods in nanoseconds; longest times round down.
  localparam int CSM_LINE50_NS = 64000;
  localparam int CSM_LINE60_NS = 63556;
  localparam logic [9:0] CSM_LINE50_CYC = 10'(CSM_LINE50_NS / CSM_CLK_NS);
  localparam logic [9:0] CSM_LINE60_CYC = 10'(CSM_LINE60_NS / CSM_CLK_NS);

  // Line sync widths in nanoseconds; least times round up.
  localparam int CSM_HS_NS = 4700;
  localparam int CSM_HS_DISC_NS = 5000;
  localparam logic [9:0] CSM_HS_CYC = 10'((CSM_HS_NS + CSM_CLK_NS - 1) / CSM_CLK_NS);
  localparam logic [9:0] CSM_HS_DISC_CYC =
    10'((CSM_HS_DISC_NS + CSM_CLK_NS - 1) / CSM_CLK_NS);

  // Lines per field without the interlace extra line.
  localparam logic [8:0] CSM_FIELD50_LINES = 9'h138;
  localparam logic [8:0] CSM_FIELD60_LINES = 9'h106;

  // Number of lines of vertical sync in each field.
  localparam logic [8:0] CSM_VS_LINES = 9'h003;

  // Ordered dither offsets for a 2x2 pattern, added before 8 to 5 bit truncation.
  localparam logic [2:0] CSM_DITH_00 = 3'h0;
  localparam logic [2:0] CSM_DITH_01 = 3'h4;
  localparam logic [2:0] CSM_DITH_10 = 3'h6;
  localparam logic [2:0] CSM_DITH_11 = 3'h2;

endpackage

// file: verilog/csm_pix_if.sv
// Pixel path bundle between the control core and the dither stage.
// Assumes both ends run on the same clock and clock enable.
`timescale 1ns/100ps
interface csm_pix_if;
  logic ce; // Shared clock enable.
  logic dither_en; // Dither mode from the control register.
  logic x0; // Pixel column parity.
  logic y0; // Line parity.
  logic in_valid; // Input pixel is present.
  logic [23:0] in_rgb; // 8:8:8 input pixel.
  logic out_valid; // Output pixel is present.
  logic [14:0] out_rgb; // 5:5:5 output pixel.

  // The core drives mode and pixels in; the dither stage answers.
  modport core (output ce, output dither_en, output x0, output y0, output in_valid,
                output in_rgb, input out_valid, input out_rgb);
  modport dith (input ce, input dither_en, input x0, input y0, input in_valid,
                input in_rgb, output out_valid, output out_rgb);
endinterface

// file: verilog/csm_dither.sv
// Dither stage: reduces 24-bit RGB to 15-bit RGB, with or without ordered dither.
// Assumes mode and pixel parity arrive on the bundle in step with the pixel.
`timescale 1ns/100ps
module csm_dither
  import csm_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst,
  csm_pix_if.dith pix
);

  // Offset chosen from the 2x2 position of the pixel.
  logic [2:0] offs;
  // Next output word.
  logic [14:0] nxt_rgb;
  // Registered output word and its valid.
  logic [14:0] rgb_ff;
  logic valid_ff;

  // Pick the pattern entry; zero when dithering is off.
  always_comb begin
    case ({pix.y0, pix.x0})
      2'b00: offs = CSM_DITH_00;
      2'b01: offs = CSM_DITH_01;
      2'b10: offs = CSM_DITH_10;
      default: offs = CSM_DITH_11;
    endcase
    // (RULE2) Dither only when enabled.
    if (!pix.dither_en) begin
      offs = 3'h0;
    end
  end

  // One channel per loop pass; the sum saturates so white never wraps to black.
  genvar ch;
  generate
    for (ch = 0; ch < 3; ch++) begin : g_chan
      logic [8:0] sum;
      always_comb begin
        sum = {1'b0, pix.in_rgb[ch*8 +: 8]} + {6'h00, offs};
        // (RULE2) Saturate then truncate.
        if (sum[8]) begin
          nxt_rgb[ch*5 +: 5] = 5'h1F;
        end else begin
          nxt_rgb[ch*5 +: 5] = sum[7:3];
        end
      end
    end
  endgenerate

  // Output register; the pixel always takes one cycle through the stage.
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      rgb_ff <= 15'h0000;
      valid_ff <= 1'b0;
    end else if (pix.ce) begin
      rgb_ff <= nxt_rgb;
      valid_ff <= pix.in_valid;
    end
  end

  assign pix.out_rgb = rgb_ff;
  assign pix.out_valid = valid_ff;

endmodule

// file: verilog/csm_top.sv
// Composite sync mode control: register, sync generator and pixel reduction path.
// Assumes synchronous inputs, one 10 MHz clock and a strobed register master.
//
// The plain strobed port and the register offsets are this design's own decisions.
`timescale 1ns/100ps
module csm_top
  import csm_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_ce,
  input wire logic [7:0] i_addr,
  input wire logic [15:0] i_wr_data,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [15:0] o_rd_data,
  input wire logic i_pix_valid,
  input wire logic [23:0] i_pix_rgb,
  output logic o_pix_valid,
  output logic [14:0] o_pix_rgb,
  output logic o_sync_n
);

  // Mode bits: fifty-hertz, disc-interactive, composite select, interlace.
  logic fifty_hz_line_standard_mode_ff;
  logic disc_interactive_sync_mode_ff;
  logic composite_select_ff;
  logic interlace_select_ff;
  // Dither enable bit.
  logic dither_enable_ff;

  // Read data register, valid only in the cycle after a read strobe.
  logic [15:0] rd_data_ff;
  logic [15:0] nxt_rd_data;

  // Horizontal position within the line, in clock cycles.
  logic [9:0] h_cnt_ff;
  logic [9:0] nxt_h_cnt;
  // Line number within the current field.
  logic [8:0] line_ff;
  logic [8:0] nxt_line;
  // Field parity; toggles at the end of every field.
  logic field_ff;
  logic nxt_field;
  // Registered sync pin, active low.
  logic sync_n_ff;
  logic nxt_sync_n;

  // Geometry that depends on the current mode.
  logic [9:0] line_cyc;
  logic [9:0] half_cyc;
  logic [9:0] hs_cyc;
  logic [8:0] field_lines;
  // Decoded sync shapes.
  logic in_vs;
  logic broad_low;
  logic hs_low;
  logic csync_low;

  // Write strobe hitting the mode control word.
  logic wr_mode;
  assign wr_mode = i_ce && i_wr && (i_addr == CSM_ADDR_MODE_CTRL);

  // Pixel bundle toward the dither stage.
  csm_pix_if pix ();

  // Sync mode bits. The qualifier bit is sampled here and never stored, so it
  // cannot steer sync; a write without it leaves all four bits untouched.
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      fifty_hz_line_standard_mode_ff <= CSM_RST_SYNC_MODE[CSM_BIT_FIFTY];
      disc_interactive_sync_mode_ff <= CSM_RST_SYNC_MODE[CSM_BIT_DISC];
      composite_select_ff <= CSM_RST_SYNC_MODE[CSM_BIT_CSEL];
      interlace_select_ff <= CSM_RST_SYNC_MODE[CSM_BIT_ILACE];
    // (RULE3) Qualified mode write.
    // (RULE5) Qualifier gates only, never stored.
    end else if (wr_mode && i_wr_data[CSM_BIT_MODE_WE]) begin
      fifty_hz_line_standard_mode_ff <= i_wr_data[CSM_BIT_FIFTY];
      disc_interactive_sync_mode_ff <= i_wr_data[CSM_BIT_DISC];
      composite_select_ff <= i_wr_data[CSM_BIT_CSEL];
      interlace_select_ff <= i_wr_data[CSM_BIT_ILACE];
    end
  end

  // Dither enable, qualified separately so either group can change alone.
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      dither_enable_ff <= CSM_RST_DITHER;
    // (RULE1) Qualified dither write.
    end else if (wr_mode && i_wr_data[CSM_BIT_DITHER_WE]) begin
      dither_enable_ff <= i_wr_data[CSM_BIT_DITHER];
    end
  end

  // Read decode. The control word is write-only and reads as zero; the status
  // word shows the stored modes, field parity and sync pin; dither enable overrides the vertical window flag in bit 5.
  always_comb begin
    nxt_rd_data = 16'h0000;
    if (i_rd && i_addr == CSM_ADDR_STATUS) begin
      nxt_rd_data[CSM_BIT_FIFTY] = fifty_hz_line_standard_mode_ff;
      nxt_rd_data[CSM_BIT_DISC] = disc_interactive_sync_mode_ff;
      nxt_rd_data[CSM_BIT_CSEL] = composite_select_ff;
      nxt_rd_data[CSM_BIT_ILACE] = interlace_select_ff;
      nxt_rd_data[CSM_ST_FIELD] = field_ff;
      nxt_rd_data[CSM_ST_IN_VS] = in_vs;
      nxt_rd_data[CSM_ST_SYNC] = sync_n_ff;
      nxt_rd_data[CSM_BIT_DITHER] = dither_enable_ff;
    end
  end

  // Read data register; it returns to zero when no read was made.
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      rd_data_ff <= 16'h0000;
    end else if (i_ce) begin
      rd_data_ff <= nxt_rd_data;
    end
  end

  // Mode-dependent geometry.
  always_comb begin
    // (RULE6) Line standard selects line length and field size.
    if (fifty_hz_line_standard_mode_ff) begin
      line_cyc = CSM_LINE50_CYC;
      field_lines = CSM_FIELD50_LINES;
    end else begin
      line_cyc = CSM_LINE60_CYC;
      field_lines = CSM_FIELD60_LINES;
    end
    // (RULE6) Interlace adds one line to even fields.
    if (interlace_select_ff && !field_ff) begin
      field_lines = field_lines + 9'h001;
    end
    // (RULE6) Disc-interactive timing widens line sync.
    if (disc_interactive_sync_mode_ff) begin
      hs_cyc = CSM_HS_DISC_CYC;
    end else begin
      hs_cyc = CSM_HS_CYC;
    end
    half_cyc = {1'b0, line_cyc[9:1]};
  end

  // Raster counters. A mode change applies at once to the line in progress; a counter
  // that was already beyond a shorter line simply wraps at once.
  always_comb begin
    nxt_h_cnt = h_cnt_ff + 10'h001;
    nxt_line = line_ff;
    nxt_field = field_ff;
    if (nxt_h_cnt >= line_cyc) begin
      nxt_h_cnt = 10'h000;
      nxt_line = line_ff + 9'h001;
      if (nxt_line >= field_lines) begin
        nxt_line = 9'h000;
        nxt_field = ~field_ff;
      end
    end
  end

  // Counter registers.
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      h_cnt_ff <= 10'h000;
      line_ff <= 9'h000;
      field_ff <= 1'b0;
    end else if (i_ce) begin
      h_cnt_ff <= nxt_h_cnt;
      line_ff <= nxt_line;
      field_ff <= nxt_field;
    end
  end

  // Vertical sync window. On odd interlaced fields it starts and ends half a
  // line late, which is what offsets the two fields on the display.
  always_comb begin
    // (RULE6) Half-line offset when interlaced.
    if (interlace_select_ff && field_ff) begin
      in_vs = (line_ff == 9'h000 && h_cnt_ff >= half_cyc) ||
              (line_ff != 9'h000 && line_ff < CSM_VS_LINES) ||
              (line_ff == CSM_VS_LINES && h_cnt_ff < half_cyc);
    end else begin
      in_vs = line_ff < CSM_VS_LINES;
    end
  end

  // Composite shapes: broad pulses twice a line inside the vertical window,
  // a short line pulse outside it.
  always_comb begin
    broad_low = (h_cnt_ff < half_cyc - hs_cyc) ||
                (h_cnt_ff >= half_cyc && h_cnt_ff < line_cyc - hs_cyc);
    hs_low = h_cnt_ff < hs_cyc;
    if (in_vs) begin
      csync_low = broad_low;
    end else begin
      csync_low = hs_low;
    end
  end

  // Sync pin selection.
  always_comb begin
    // (RULE4) Composite or vertical sync.
    if (composite_select_ff) begin
      nxt_sync_n = ~csync_low;
    end else begin
      nxt_sync_n = ~in_vs;
    end
  end

  // Sync pin register, idle high from reset.
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      sync_n_ff <= 1'b1;
    end else if (i_ce) begin
      sync_n_ff <= nxt_sync_n;
    end
  end

  // Pixel path into the dither stage; parity follows the raster counters.
  assign pix.ce = i_ce;
  // (RULE2) Dither mode drives the reduction.
  assign pix.dither_en = dither_enable_ff;
  assign pix.x0 = h_cnt_ff[0];
  assign pix.y0 = line_ff[0];
  assign pix.in_valid = i_pix_valid;
  assign pix.in_rgb = i_pix_rgb;

  // Dither stage; its output register feeds the pixel pins directly.
  csm_dither u_dither (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .pix(pix)
  );

  // Outputs, each straight from a register.
  assign o_rd_data = rd_data_ff;
  assign o_pix_valid = pix.out_valid;
  assign o_pix_rgb = pix.out_rgb;
  assign o_sync_n = sync_n_ff;

endmodule

// file: verification/csm_chk_sva.sv
// Checker for the composite sync mode control block, watching its top ports only.
// Assumes one clock; it mirrors the control word from the register strobes.
`timescale 1ns/100ps
module csm_chk
  import csm_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_ce,
  input wire logic [7:0] i_addr,
  input wire logic [15:0] i_wr_data,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [15:0] o_rd_data,
  input wire logic i_pix_valid,
  input wire logic [23:0] i_pix_rgb,
  input wire logic o_pix_valid,
  input wire logic [14:0] o_pix_rgb,
  input wire logic o_sync_n
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst);
  logic [3:0] mode_ff; // Mirrored sync mode bits.
  logic dith_ff; // Mirrored dither enable.
  logic [11:0] low_cnt_ff; // Length of the current low run on the sync pin.
  logic wr_seen_ff; // A mode write landed since the last rise, so that run is excused.
  logic wr_ok; // A control write that the block takes.
  assign wr_ok = i_ce && i_wr && i_addr == CSM_ADDR_MODE_CTRL;

  // Mirror the control word; each group moves only with its qualifier.
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      mode_ff <= CSM_RST_SYNC_MODE;
      dith_ff <= CSM_RST_DITHER;
    end else if (wr_ok) begin
      if (i_wr_data[CSM_BIT_MODE_WE]) mode_ff <= i_wr_data[3:0];
      if (i_wr_data[CSM_BIT_DITHER_WE]) dith_ff <= i_wr_data[CSM_BIT_DITHER];
    end
  end

  // Measure low runs; a mode change mid-run would make its length meaningless.
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      low_cnt_ff <= 12'h000;
      wr_seen_ff <= 1'b0;
    end else if (i_ce) begin
      low_cnt_ff <= o_sync_n ? 12'h000 : low_cnt_ff + 12'h001;
      if (wr_ok && i_wr_data[CSM_BIT_MODE_WE]) wr_seen_ff <= 1'b1;
      else if (o_sync_n && low_cnt_ff != 12'h000) wr_seen_ff <= 1'b0;
    end
  end

  property p_dith_off;
    i_ce && i_pix_valid && !dith_ff |=> o_pix_rgb ==
      {$past(i_pix_rgb[23:19]), $past(i_pix_rgb[15:11]), $past(i_pix_rgb[7:3])};
  endproperty
  a_dith_off: assert property (p_dith_off)
    else $error("pixel not truncated with dither off");
  property p_dith_on;
    i_ce && i_pix_valid && dith_ff |=> 5'(o_pix_rgb[14:10] - $past(i_pix_rgb[23:19])) <= 5'h01;
  endproperty
  a_dith_on: assert property (p_dith_on)
    else $error("dithered red off by more than one step");
  property p_pix_vld;
    i_ce |=> o_pix_valid == $past(i_pix_valid);
  endproperty
  a_pix_vld: assert property (p_pix_vld)
    else $error("pixel valid not one cycle later");
  property p_dith_stat;
    i_ce && i_rd && i_addr == CSM_ADDR_STATUS |=> o_rd_data[CSM_BIT_DITHER] == $past(dith_ff);
  endproperty
  a_dith_stat: assert property (p_dith_stat)
    else $error("dither enable differs from writes");
  property p_mode_stat;
    i_ce && i_rd && i_addr == CSM_ADDR_STATUS |=> o_rd_data[3:0] == $past(mode_ff);
  endproperty
  a_mode_stat: assert property (p_mode_stat)
    else $error("sync mode bits differ from writes");
  property p_vsync_long;
    !mode_ff[CSM_BIT_CSEL] && !wr_seen_ff && $rose(o_sync_n) |-> low_cnt_ff >= 12'h76C;
  endproperty
  a_vsync_long: assert property (p_vsync_long)
    else $error("vertical sync pulse shorter than three lines");
  // A composite low run is either a line pulse of the mode's width or a broad pulse.
  property p_csync_width;
    mode_ff[CSM_BIT_CSEL] && !wr_seen_ff && $rose(o_sync_n) |->
      low_cnt_ff == (mode_ff[CSM_BIT_DISC] ? CSM_HS_DISC_CYC : CSM_HS_CYC) ||
      low_cnt_ff >= 12'h100;
  endproperty
  a_csync_width: assert property (p_csync_width)
    else $error("composite line pulse width wrong for the mode");
endmodule

bind csm_top csm_chk u_chk (.i_clk(i_clk), .i_rst(i_rst), .i_ce(i_ce), .i_addr(i_addr),
  .i_wr_data(i_wr_data), .i_wr(i_wr), .i_rd(i_rd), .o_rd_data(o_rd_data),
  .i_pix_valid(i_pix_valid), .i_pix_rgb(i_pix_rgb), .o_pix_valid(o_pix_valid),
  .o_pix_rgb(o_pix_rgb), .o_sync_n(o_sync_n));

// file: verification/csm_sync_rx.sv
// Display model on the sync pin: counts the starts of sync pulses.
// Assumes an active low pin sampled on the design clock.
`timescale 1ns/100ps
module csm_sync_rx (
  input wire logic i_clk,
  input wire logic i_sync_n
);
  logic prev = 1'b1; // Pin level at the previous edge.
  int falls = 0; // Pulses seen; the display locks on these.

  // A falling edge starts a pulse.
  always @(posedge i_clk) begin
    prev <= i_sync_n;
    if (prev && !i_sync_n) falls <= falls + 1;
  end
endmodule

// file: verification/testbench.sv
// Self-checking bench for the composite sync mode control block.
// Assumes the design package and the sync receiver model beside the design.
`timescale 1ns/100ps
module testbench
  import csm_pkg::*;
;
  logic i_clk = 1'b0;
  logic i_rst = 1'b1;
  logic i_ce = 1'b1;
  logic [7:0] i_addr = 8'h00;
  logic [15:0] i_wr_data = 16'h0000;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic i_pix_valid = 1'b0;
  logic [23:0] i_pix_rgb = 24'h000000;
  logic [15:0] o_rd_data;
  logic o_pix_valid;
  logic [14:0] o_pix_rgb;
  logic o_sync_n;
  int fails = 0;
  int checks_done = 0;

  // Clock of 100 ns.
  always #50 i_clk = ~i_clk;

  csm_top i_dut (.i_clk(i_clk), .i_rst(i_rst), .i_ce(i_ce), .i_addr(i_addr),
    .i_wr_data(i_wr_data), .i_wr(i_wr), .i_rd(i_rd), .o_rd_data(o_rd_data),
    .i_pix_valid(i_pix_valid), .i_pix_rgb(i_pix_rgb), .o_pix_valid(o_pix_valid),
    .o_pix_rgb(o_pix_rgb), .o_sync_n(o_sync_n));
  csm_sync_rx i_rx (.i_clk(i_clk), .i_sync_n(o_sync_n));

  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] s);
    checks_done++;
    if (s !== e) begin
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
      fails++;
    end
  endtask

  // One-cycle strobes; a gap cycle keeps each strobe assigned once per step.
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge i_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wr_data <= d;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [15:0] m, input logic [15:0] e);
    @(posedge i_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1;
    chk("read data", e, o_rd_data & m);
  endtask

  task automatic pix(input logic [23:0] rgb, input logic [14:0] e);
    @(posedge i_clk);
    i_pix_valid <= 1'b1;
    i_pix_rgb <= rgb;
    @(posedge i_clk);
    i_pix_valid <= 1'b0;
    #1;
    chk("pixel", {1'b0, e}, {1'b0, o_pix_rgb});
    chk("pixel valid", 16'h0001, {15'h0000, o_pix_valid});
  endtask

  // Reset modes, and the control word reads back nothing.
  task automatic t_reset;
    rd(CSM_ADDR_STATUS, 16'h002F, 16'h0008);
    rd(CSM_ADDR_MODE_CTRL, 16'hFFFF, 16'h0000);
  endtask

  // Vertical sync gives one long pulse; composite gives a pulse every line.
  task automatic t_sync;
    int f;
    f = i_rx.falls;
    repeat (2000) @(posedge i_clk);
    chk("vertical pulses", 16'h0000, 16'(i_rx.falls - f));
    // Composite with disc-interactive and fifty-hertz timing, so the wide pulse is seen.
    wr(CSM_ADDR_MODE_CTRL, 16'h0017);
    f = i_rx.falls;
    repeat (1300) @(posedge i_clk);
    chk("composite pulses", 16'h0001, 16'(i_rx.falls - f >= 2));
  endtask

  // Mode bits move only with bit 4, which itself is not stored.
  task automatic t_mode;
    wr(CSM_ADDR_MODE_CTRL, 16'h000B);
    rd(CSM_ADDR_STATUS, 16'h002F, 16'h0007);
    wr(CSM_ADDR_MODE_CTRL, 16'h001B);
    rd(CSM_ADDR_STATUS, 16'h002F, 16'h000B);
  endtask

  // Dither bit moves only with its own enable, and never from another address.
  task automatic t_dither;
    wr(CSM_ADDR_MODE_CTRL, 16'h0020);
    rd(CSM_ADDR_STATUS, 16'h002F, 16'h000B);
    wr(CSM_ADDR_MODE_CTRL, 16'h0060);
    rd(CSM_ADDR_STATUS, 16'h002F, 16'h002B);
    wr(CSM_ADDR_STATUS, 16'h0040);
    rd(CSM_ADDR_STATUS, 16'h002F, 16'h002B);
    wr(CSM_ADDR_MODE_CTRL, 16'h0040);
    rd(CSM_ADDR_STATUS, 16'h002F, 16'h000B);
  endtask

  // Plain truncation, then dither at both extremes, saturating at white.
  task automatic t_pix;
    pix(24'hFFFFFF, 15'h7FFF);
    pix(24'h80FF08, 15'h43E1);
    wr(CSM_ADDR_MODE_CTRL, 16'h0060);
    pix(24'hFFFFFF, 15'h7FFF);
    pix(24'h000000, 15'h0000);
  endtask

  // Dither on: of two neighbouring pixels at least one gets a non-zero offset, since the
  // column parity alternates; a value of 7 per channel then rounds up to 1.
  task automatic t_dith_on;
    logic [14:0] seen;
    @(posedge i_clk);
    i_pix_valid <= 1'b1;
    i_pix_rgb <= 24'h070707;
    @(posedge i_clk);
    #1;
    seen = o_pix_rgb;
    @(posedge i_clk);
    i_pix_valid <= 1'b0;
    #1;
    seen = seen | o_pix_rgb;
    chk("dithered pixel", 16'h0421, {1'b0, seen});
  endtask

  // A write while the clock enable is low is lost.
  task automatic t_ce;
    @(posedge i_clk);
    i_ce <= 1'b0;
    wr(CSM_ADDR_MODE_CTRL, 16'h0040);
    i_ce <= 1'b1;
    rd(CSM_ADDR_STATUS, 16'h002F, 16'h002B);
  endtask

  task automatic summarize;
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  // Main sequence after five cycles of reset.
  initial begin
    repeat (5) @(posedge i_clk);
    i_rst <= 1'b0;
    t_reset;
    t_sync;
    t_mode;
    t_dither;
    t_pix;
    t_dith_on;
    t_ce;
    summarize;
  end

  // Watchdog: the tests need about 3500 cycles.
  initial begin
    #(100 * 20000);
    fails++;
    summarize;
  end
endmodule
